// ===== core/second_level_pde_pte_walker.sv
`default_nettype none
// Lower walk levels of second-level translation, APB controlled
module second_level_pde_pte_walker #(
	parameter int PA_WIDTH = 52
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic mem_req_valid,
	output logic [63:0] mem_req_addr,
	input wire logic mem_req_ready,
	input wire logic mem_rsp_valid,
	input wire logic [63:0] mem_rsp_data,
	output logic walk_busy,
	output logic walk_done
);
	// ****************************************
	// Software state
	// ****************************************
	logic [3:1] acc_req;        // Requested read, write, fetch
	logic ve_en;                // Violation-to-exception control
	logic [31:0] root;          // Walk root pointer low word
	logic [63:0] gpa;           // Guest-physical address
	logic [63:0] ptr;           // Pointer-level entry
	// ****************************************
	// Walk state and results
	// ****************************************
	slpt_pkg::walk_state_t state;
	logic [63:0] entry;         // Latched fetched entry
	logic [2:0] perm_acc;       // Permissions of levels above
	logic [63:0] out_addr;      // Final physical address
	logic viol;                 // Translation violation
	logic misconf;              // Misconfiguration
	logic ve;                   // Converted to exception
	logic page_2m;              // Mapped a 2-MByte page
	logic fault_leaf;           // Walk ended at leaf level
	logic [2:0] res_perm;       // Effective permissions
	logic [2:0] res_mt;         // Final memory type
	logic res_ipat;             // Ignore attribute table
	logic res_acc;              // Accessed seen
	logic res_dirty;            // Dirty seen
	logic res_sve;              // Suppress bit of last entry

	// ****************************************
	// APB decode
	// ****************************************
	wire logic setup_acc = psel && penable && !pready;  // Access, answer pending
	wire logic wr_fire = psel && penable && pready && pwrite;
	wire logic sel_ctrl = paddr == slpt_pkg::OFS_CTRL;
	wire logic sel_root = paddr == slpt_pkg::OFS_ROOT;
	wire logic sel_glo = paddr == slpt_pkg::OFS_GPA_LO;
	wire logic sel_ghi = paddr == slpt_pkg::OFS_GPA_HI;
	wire logic sel_plo = paddr == slpt_pkg::OFS_PTR_LO;
	wire logic sel_phi = paddr == slpt_pkg::OFS_PTR_HI;
	wire logic sel_stat = paddr == slpt_pkg::OFS_STATUS;
	wire logic sel_olo = paddr == slpt_pkg::OFS_OUT_LO;
	wire logic sel_ohi = paddr == slpt_pkg::OFS_OUT_HI;
	wire logic sel_attr = paddr == slpt_pkg::OFS_ATTR;
	wire logic hit = sel_ctrl || sel_root || sel_glo || sel_ghi || sel_plo ||
		sel_phi || sel_stat || sel_olo || sel_ohi || sel_attr;
	// Start is ignored while a walk is running
	wire logic start = wr_fire && sel_ctrl && pwdata[slpt_pkg::CTRL_START] &&
		state == slpt_pkg::ST_IDLE;
	wire logic ad_on = root[slpt_pkg::ROOT_AD_BIT];  // RULE11 RULE15

	// Status and attribute words
	wire logic [31:0] stat_word = {25'h0, fault_leaf, page_2m, ve, misconf, viol,
		walk_done, walk_busy};
	wire logic [31:0] attr_word = {20'h0, res_sve, res_dirty, res_acc, res_ipat,
		1'b0, res_mt, 1'b0, res_perm};
	wire logic [31:0] ctrl_word = {27'h0, ve_en, acc_req, 1'b0};
	wire logic [31:0] rd_mux =
		sel_ctrl ? ctrl_word :
		sel_root ? root :
		sel_glo ? gpa[31:0] :
		sel_ghi ? gpa[63:32] :
		sel_plo ? ptr[31:0] :
		sel_phi ? ptr[63:32] :
		sel_stat ? stat_word :
		sel_olo ? out_addr[31:0] :
		sel_ohi ? out_addr[63:32] :
		sel_attr ? attr_word : slpt_pkg::RST_WORD;

	// ****************************************
	// Entry decode
	// ****************************************
	entry_dec_if dec ();
	assign dec.entry = entry;
	assign dec.at_dir = state == slpt_pkg::ST_DIR_CHK;
	assign dec.ad_on = ad_on;
	entry_decoder #(.PA_WIDTH(PA_WIDTH)) u_dec (.d(dec));

	// ****************************************
	// Address formation
	// ****************************************
	// Directory entry address from pointer entry base
	wire logic [63:0] dir_addr = {12'h0, ptr[51:12], gpa[29:21], 3'h0};  // RULE1 RULE17
	// Leaf entry address from directory entry base
	wire logic [63:0] leaf_addr = {12'h0, entry[51:12], gpa[20:12], 3'h0};  // RULE3 RULE4
	wire logic [63:0] map2m = {12'h0, entry[51:21], gpa[20:0]};  // RULE2
	wire logic [63:0] map4k = {12'h0, entry[51:12], gpa[11:0]};  // RULE5
	// Permissions including the entry under check
	wire logic [2:0] next_perm = perm_acc & dec.perm;  // RULE14
	wire logic perm_deny = |(acc_req & ~next_perm);  // RULE22
	wire logic chk = state == slpt_pkg::ST_DIR_CHK || state == slpt_pkg::ST_LEAF_CHK;
	// Not present, or present but refusing the access
	wire logic next_viol = !dec.present || perm_deny;  // RULE6 RULE7
	wire logic finish = chk && (!dec.present || dec.misconf || dec.is_map);

	// ****************************************
	// APB answer: one wait state per access
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= slpt_pkg::RST_WORD;
			pslverr <= 1'b0;
		end else begin
			pready <= setup_acc;
			prdata <= setup_acc ? rd_mux : slpt_pkg::RST_WORD;
			pslverr <= setup_acc && !hit;
		end
	end

	// ****************************************
	// Software registers
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_req <= 3'h0;
			ve_en <= 1'b0;
			root <= slpt_pkg::RST_WORD;
		end else if (wr_fire && sel_ctrl) begin
			acc_req <= pwdata[slpt_pkg::CTRL_ACC_LSB +: 3];
			ve_en <= pwdata[slpt_pkg::CTRL_VE_EN];
		end else if (wr_fire && sel_root) begin
			root <= pwdata;
		end
	end

	// Address and pointer entry words
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gpa <= slpt_pkg::RST_DWORD;
			ptr <= slpt_pkg::RST_DWORD;
		end else if (wr_fire) begin
			if (sel_glo) gpa[31:0] <= pwdata;
			if (sel_ghi) gpa[63:32] <= pwdata;
			if (sel_plo) ptr[31:0] <= pwdata;
			if (sel_phi) ptr[63:32] <= pwdata;
		end
	end

	// ****************************************
	// Walk sequencer
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= slpt_pkg::ST_IDLE;
			mem_req_valid <= 1'b0;
			mem_req_addr <= slpt_pkg::RST_DWORD;
			entry <= slpt_pkg::RST_DWORD;
			perm_acc <= 3'h0;
		end else begin
			case (state)
				// Launch directory fetch
				slpt_pkg::ST_IDLE: begin
					if (start) begin
						mem_req_valid <= 1'b1;
						mem_req_addr <= dir_addr;  // RULE1
						perm_acc <= ptr[2:0];
						state <= slpt_pkg::ST_DIR_REQ;
					end
				end
				// Hold request until accepted
				slpt_pkg::ST_DIR_REQ: begin
					if (mem_req_ready) begin
						mem_req_valid <= 1'b0;  // RULE21
						state <= slpt_pkg::ST_DIR_WAIT;
					end
				end
				// Wait for returned entry
				slpt_pkg::ST_DIR_WAIT: begin
					if (mem_rsp_valid) begin
						entry <= mem_rsp_data;  // RULE21
						state <= slpt_pkg::ST_DIR_CHK;
					end
				end
				// Map, fault, or descend
				slpt_pkg::ST_DIR_CHK: begin
					if (finish) begin
						state <= slpt_pkg::ST_IDLE;
					end else begin
						mem_req_valid <= 1'b1;
						mem_req_addr <= leaf_addr;  // RULE3 RULE4
						perm_acc <= next_perm;  // RULE14
						state <= slpt_pkg::ST_LEAF_REQ;
					end
				end
				// Hold leaf request until accepted
				slpt_pkg::ST_LEAF_REQ: begin
					if (mem_req_ready) begin
						mem_req_valid <= 1'b0;  // RULE21
						state <= slpt_pkg::ST_LEAF_WAIT;
					end
				end
				// Wait for leaf entry
				slpt_pkg::ST_LEAF_WAIT: begin
					if (mem_rsp_valid) begin
						entry <= mem_rsp_data;
						state <= slpt_pkg::ST_LEAF_CHK;
					end
				end
				// Leaf always finishes the walk
				slpt_pkg::ST_LEAF_CHK: begin
					state <= slpt_pkg::ST_IDLE;
				end
				default: begin
					state <= slpt_pkg::ST_IDLE;
					mem_req_valid <= 1'b0;
				end
			endcase
		end
	end

	// ****************************************
	// Busy and done indication
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			walk_busy <= 1'b0;
			walk_done <= 1'b0;
		end else begin
			walk_busy <= start || (walk_busy && !finish);
			// Done holds until the next start
			walk_done <= finish || (walk_done && !start);
		end
	end

	// ****************************************
	// Result capture
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_addr <= slpt_pkg::RST_DWORD;
			viol <= 1'b0;
			misconf <= 1'b0;
			ve <= 1'b0;
			page_2m <= 1'b0;
			fault_leaf <= 1'b0;
		end else if (start) begin
			out_addr <= slpt_pkg::RST_DWORD;
			viol <= 1'b0;
			misconf <= 1'b0;
			ve <= 1'b0;
			page_2m <= 1'b0;
			fault_leaf <= 1'b0;
		end else if (finish) begin
			// Misconfiguration takes priority over violation
			misconf <= dec.misconf;  // RULE18 RULE19 RULE20
			viol <= !dec.misconf && next_viol;  // RULE7 RULE22
			ve <= !dec.misconf && next_viol && ve_en && !dec.sve;  // RULE8
			fault_leaf <= state == slpt_pkg::ST_LEAF_CHK;
			// Address formed only for a usable mapping
			if (!dec.misconf && !next_viol) begin
				page_2m <= state == slpt_pkg::ST_DIR_CHK;
				out_addr <= (state == slpt_pkg::ST_DIR_CHK) ? map2m : map4k;  // RULE2 RULE5
			end
		end
	end

	// Page attributes of the final entry
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			res_perm <= 3'h0;
			res_mt <= 3'h0;
			res_ipat <= 1'b0;
			res_acc <= 1'b0;
			res_dirty <= 1'b0;
			res_sve <= 1'b0;
		end else if (finish) begin
			res_perm <= next_perm;  // RULE9
			res_mt <= dec.mtype;  // RULE10
			res_ipat <= dec.ipat;  // RULE10
			res_acc <= dec.acc;  // RULE11
			res_dirty <= dec.dirty;  // RULE11
			res_sve <= dec.sve;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_DIR_ADDR: assert property (state == slpt_pkg::ST_DIR_REQ |->  // RULE1
		mem_req_addr == {12'h0, ptr[51:12], gpa[29:21], 3'h0})
		else $error("directory entry address wrong");
	AST_REQ_HOLD: assert property (mem_req_valid && !mem_req_ready |=>  // RULE21
		mem_req_valid && $stable(mem_req_addr))
		else $error("request dropped before acceptance");
	AST_LEAF_GO: assert property (state == slpt_pkg::ST_DIR_CHK && dec.present &&  // RULE3
		!dec.misconf && !dec.is_map |=> state == slpt_pkg::ST_LEAF_REQ &&
		mem_req_addr == {12'h0, $past(entry[51:12]), gpa[20:12], 3'h0})
		else $error("leaf fetch not launched");
	AST_MAP_2M: assert property (state == slpt_pkg::ST_DIR_CHK && dec.is_map &&  // RULE2
		!dec.misconf && !next_viol |=> page_2m && walk_done &&
		out_addr[20:0] == gpa[20:0] && out_addr[63:52] == 12'h0)
		else $error("2-MByte mapping wrong");
	AST_MAP_4K: assert property (state == slpt_pkg::ST_LEAF_CHK && !dec.misconf &&  // RULE5
		!next_viol |=> !page_2m && out_addr == {12'h0, $past(entry[51:12]), gpa[11:0]})
		else $error("4-KByte mapping wrong");
	AST_NOT_PRESENT: assert property (chk && entry[2:0] == 3'h0 |=>  // RULE7
		viol && !misconf && walk_done && state == slpt_pkg::ST_IDLE)
		else $error("not-present entry did not violate");
	AST_VE_GATE: assert property ($rose(ve) |-> ve_en && viol && !res_sve)  // RULE8
		else $error("exception without control or with suppress");
	// Flags are judged at the finishing edge; a later root write must not trip this
	AST_AD_OFF: assert property (finish && !ad_on |=> !res_acc && !res_dirty)  // RULE11
		else $error("accessed/dirty reported while disabled");
	AST_BAD_PERM: assert property (chk && (entry[2:0] == 3'h2 ||  // RULE19
		entry[2:0] == 3'h6) |=> misconf && !viol)
		else $error("write-only permission not misconfigured");
	AST_DENY: assert property (finish && !dec.misconf && dec.present &&  // RULE22
		perm_deny |=> viol)
		else $error("refused access not reported");
	// A misconfigured entry never yields an address, a violation or an exception
	AST_MISCONF_WINS: assert property (finish && dec.misconf |=>  // RULE18
		misconf && !viol && !ve && !page_2m && out_addr == slpt_pkg::RST_DWORD)
		else $error("misconfiguration did not take priority");
	// A not-present entry is used neither for a fetch nor for an address
	AST_NP_NO_ADDR: assert property (finish && !dec.present |=>  // RULE6
		out_addr == slpt_pkg::RST_DWORD && !page_2m && !mem_req_valid)
		else $error("not-present entry used further");
	// Leaf permissions are those of the leaf limited by the levels above
	AST_LEAF_PERM: assert property (state == slpt_pkg::ST_LEAF_CHK |=>  // RULE14
		res_perm == ($past(perm_acc) & $past(entry[2:0])))
		else $error("leaf permissions not combined");
	// A 2-MByte mapping reports its own memory type and ignore-attribute bit
	AST_2M_ATTR: assert property (state == slpt_pkg::ST_DIR_CHK && dec.is_map |=>  // RULE10
		res_mt == $past(entry[5:3]) && res_ipat == $past(entry[6]))
		else $error("2-MByte page attributes wrong");
endmodule
`default_nettype wire

// ===== core/slpt_pkg.sv
// Summary of operation
// RULE1: Directory entry address from pointer base, GPA 29:21
// RULE2: Bit 7 set maps 2-MByte page
// RULE3: Bit 7 clear continues to leaf table
// RULE4: Leaf entry address from directory base, GPA 20:12
// RULE5: Present leaf maps 4-KByte page
// RULE6: Bits 2:0 zero means not present
// RULE7: Not-present entry gives translation violation
// RULE8: Exception only if control set, bit 63 clear
// RULE9: Map entry bits 0-2 grant read/write/fetch
// RULE10: Map entry memory type 5:3, bit 6 ignore-attribute
// RULE11: Bits 8/9 accessed/dirty only when root bit 6
// RULE12: 2-MByte entry reserved 20:12 and 51:N
// RULE13: Table directory entry reserved 6:3 and 51:N
// RULE14: Table directory entry permissions cover whole region
// RULE15: Table directory bit 8 accessed when enabled
// RULE16: Field split parameterised by physical width N
// RULE17: Pointer entry bits 51:12 give directory base
// RULE18: Present entry with reserved bit is misconfiguration
// RULE19: Write-only or write-execute permission is misconfiguration
// RULE20: Final memory type 2, 3, 7 is misconfiguration
// RULE21: Fetch holds address until accepted, awaits entry
// RULE22: Combined permissions refusing access give violation
`default_nettype none
package slpt_pkg;
	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_ROOT = 12'h004;
	localparam logic [11:0] OFS_GPA_LO = 12'h008;
	localparam logic [11:0] OFS_GPA_HI = 12'h00C;
	localparam logic [11:0] OFS_PTR_LO = 12'h010;
	localparam logic [11:0] OFS_PTR_HI = 12'h014;
	localparam logic [11:0] OFS_STATUS = 12'h018;
	localparam logic [11:0] OFS_OUT_LO = 12'h01C;
	localparam logic [11:0] OFS_OUT_HI = 12'h020;
	localparam logic [11:0] OFS_ATTR = 12'h024;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int CTRL_START = 0;
	localparam int CTRL_ACC_LSB = 1;
	localparam int CTRL_VE_EN = 4;
	localparam int ROOT_AD_BIT = 6;
	localparam int E_MT_LSB = 3;
	localparam int E_IPAT_BIT = 6;
	localparam int E_MAP_BIT = 7;
	localparam int E_ACC_BIT = 8;
	localparam int E_DIRTY_BIT = 9;
	localparam int E_SVE_BIT = 63;
	// ****************************************
	// Reset values and encodings
	// ****************************************
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [63:0] RST_DWORD = 64'h0000_0000_0000_0000;
	localparam logic [2:0] PERM_WO = 3'h2;
	localparam logic [2:0] PERM_WX = 3'h6;
	// Walker states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_DIR_REQ = 3'b001,
		ST_DIR_WAIT = 3'b010,
		ST_DIR_CHK = 3'b011,
		ST_LEAF_REQ = 3'b100,
		ST_LEAF_WAIT = 3'b101,
		ST_LEAF_CHK = 3'b110
	} walk_state_t;
endpackage
`default_nettype wire

// ===== core/entry_dec_if.sv
`default_nettype none
// Entry under test and its decoded fields
interface entry_dec_if;
	logic [63:0] entry;  // Fetched entry
	logic at_dir;        // Entry is a directory entry
	logic ad_on;         // Accessed/dirty tracking enabled
	logic present;       // Bits 2:0 not all zero
	logic is_map;        // Entry maps a page
	logic [2:0] perm;    // Read, write, fetch
	logic [2:0] mtype;   // Memory type
	logic ipat;          // Ignore guest attribute table type
	logic sve;           // Suppress exception
	logic acc;           // Accessed flag
	logic dirty;         // Dirty flag
	logic misconf;       // Unsupported value
	modport walker(output entry, at_dir, ad_on,
		input present, is_map, perm, mtype, ipat, sve, acc, dirty, misconf);
	modport decoder(input entry, at_dir, ad_on,
		output present, is_map, perm, mtype, ipat, sve, acc, dirty, misconf);
endinterface
`default_nettype wire

// ===== core/entry_decoder.sv
`default_nettype none
// Combinational decode of one directory or leaf entry
module entry_decoder #(
	parameter int PA_WIDTH = 52
) (
	entry_dec_if.decoder d
);
	// ****************************************
	// Field extraction
	// ****************************************
	wire logic [2:0] perm = d.entry[2:0];  // RULE9 RULE14
	wire logic present = |perm;  // RULE6
	wire logic map_bit = d.entry[slpt_pkg::E_MAP_BIT];
	// Leaf entries always map; bit 7 ignored there
	wire logic is_map = d.at_dir ? map_bit : 1'b1;  // RULE2 RULE3
	wire logic [2:0] mtype = d.entry[slpt_pkg::E_MT_LSB +: 3];  // RULE10
	// Address bits at or above the physical width
	wire logic hi_rsv = |(d.entry[51:0] >> PA_WIDTH);  // RULE16
	// Level-specific reserved fields
	wire logic lvl_rsv = d.at_dir &&
		(map_bit ? |d.entry[20:12] : |d.entry[6:3]);  // RULE12 RULE13
	wire logic bad_perm = perm == slpt_pkg::PERM_WO ||
		perm == slpt_pkg::PERM_WX;  // RULE19
	wire logic bad_mt = is_map && (mtype == 3'h2 || mtype == 3'h3 ||
		mtype == 3'h7);  // RULE20
	// ****************************************
	// Outputs
	// ****************************************
	assign d.present = present;
	assign d.is_map = is_map;
	assign d.perm = perm;
	assign d.mtype = mtype;
	assign d.ipat = is_map && d.entry[slpt_pkg::E_IPAT_BIT];
	assign d.sve = d.entry[slpt_pkg::E_SVE_BIT];
	// Flags ignored unless tracking enabled
	assign d.acc = d.ad_on && d.entry[slpt_pkg::E_ACC_BIT];  // RULE11 RULE15
	assign d.dirty = d.ad_on && is_map && d.entry[slpt_pkg::E_DIRTY_BIT];  // RULE11
	// Not-present entries never misconfigure
	assign d.misconf = present && (hi_rsv || lvl_rsv || bad_perm || bad_mt);  // RULE18
endmodule
`default_nettype wire

// ===== sim/slpt_mem_model.sv
`default_nettype none
// Table memory behind the walker: accepts one fetch, answers after a delay
module slpt_mem_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic mem_req_valid,
	input wire logic [63:0] mem_req_addr,
	output logic mem_req_ready,
	output logic mem_rsp_valid,
	output logic [63:0] mem_rsp_data
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [63:0] mem [logic [63:0]]; // Table contents, absent reads as zero
	logic [63:0] addrs [$]; // Accepted fetch addresses
	logic [63:0] a; // Address of the fetch in progress
	// ****************************************
	// Handshake
	// ****************************************
	// Waits a random time before accepting and before answering
	initial begin
		mem_req_ready = 1'b0;
		mem_rsp_valid = 1'b0;
		mem_rsp_data = 64'h0;
		forever begin
			@(posedge pclk);
			if (presetn === 1'b1 && mem_req_valid === 1'b1) begin
				repeat ($urandom_range(0, 3)) @(posedge pclk);
				mem_req_ready <= 1'b1;
				@(posedge pclk);
				a = mem_req_addr;
				addrs.push_back(a);
				mem_req_ready <= 1'b0;
				repeat ($urandom_range(0, 4)) @(posedge pclk);
				mem_rsp_valid <= 1'b1;
				mem_rsp_data <= mem.exists(a) ? mem[a] : 64'h0;
				@(posedge pclk);
				mem_rsp_valid <= 1'b0;
				// Released data shows a changed value, never the old entry
				mem_rsp_data <= ~mem_rsp_data;
			end
		end
	end
endmodule
`default_nettype wire

// ===== sim/second_level_pde_pte_walker_tb.sv
`default_nettype none
// Self-checking bench for the lower walk levels
module second_level_pde_pte_walker_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int PAW = 40; // Reduced physical width to reach reserved high bits
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic re;
	logic mem_req_valid, mem_req_ready, mem_rsp_valid, walk_busy, walk_done;
	logic [63:0] mem_req_addr, mem_rsp_data, gpa, ptr, o;
	int err_count, checked;
	// ****************************************
	// Design and memory partner
	// ****************************************
	second_level_pde_pte_walker #(.PA_WIDTH(PAW)) DUT (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req_valid(mem_req_valid),
		.mem_req_addr(mem_req_addr), .mem_req_ready(mem_req_ready),
		.mem_rsp_valid(mem_rsp_valid), .mem_rsp_data(mem_rsp_data),
		.walk_busy(walk_busy), .walk_done(walk_done));
	slpt_mem_model u_mem (.pclk(pclk), .presetn(presetn), .mem_req_valid(mem_req_valid),
		.mem_req_addr(mem_req_addr), .mem_req_ready(mem_req_ready),
		.mem_rsp_valid(mem_rsp_valid), .mem_rsp_data(mem_rsp_data));
	// Clock at 250 MHz
	always #2 pclk = ~pclk;
	// ****************************************
	// Tasks
	// ****************************************
	// Verdict and end of run
	task close_out;
		$display("errors %0d, comparisons %0d", err_count, checked);
		if (err_count == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// Compare one value
	task chk(input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One APB transfer; result in rd and re
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			err_count++;
			close_out;
		end
		rd = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Random address aligned to 2**sh inside the physical width
	function automatic logic [63:0] at(input int sh);
		logic [63:0] v;
		v = {$urandom, $urandom} & 64'h0000_00FF_FFFF_FFFF;
		return (v >> sh) << sh;
	endfunction
	// Reserved or unsupported values in a present entry
	function automatic logic misc(input logic [63:0] e, input logic isdir);
		logic m;
		if (e[2:0] == 3'h0) return 1'b0;
		m = e[2:0] == 3'h2 || e[2:0] == 3'h6 || (e[51:0] >> PAW) != 0;
		if (isdir && e[7]) m |= e[20:12] != 0;
		if (isdir && !e[7]) m |= e[6:3] != 0;
		if (!isdir || e[7]) m |= e[5:3] == 3'h2 || e[5:3] == 3'h3 || e[5:3] == 3'h7;
		return m;
	endfunction
	// One walk against the bench model
	task run(input logic [63:0] dir, input logic [63:0] leaf, input logic [2:0] req,
		input logic ve, input logic ad);
		logic [63:0] da, la, last;
		logic mis, vio, lf, exc, flt;
		logic [2:0] perm;
		int nf, n;
		gpa = {$urandom, $urandom} & 64'h0000_FFFF_FFFF_FFFF;
		ptr = at(12) | 64'h7;
		da = {12'h0, ptr[51:12], gpa[29:21], 3'h0};
		la = {12'h0, dir[51:12], gpa[20:12], 3'h0};
		u_mem.mem.delete();
		u_mem.addrs.delete();
		u_mem.mem[da] = dir;
		u_mem.mem[la] = leaf;
		apb(1'b1, slpt_pkg::OFS_ROOT, {25'h0, ad, 6'h0});
		apb(1'b1, slpt_pkg::OFS_GPA_LO, gpa[31:0]);
		apb(1'b1, slpt_pkg::OFS_GPA_HI, gpa[63:32]);
		apb(1'b1, slpt_pkg::OFS_PTR_LO, ptr[31:0]);
		apb(1'b1, slpt_pkg::OFS_PTR_HI, ptr[63:32]);
		apb(1'b1, slpt_pkg::OFS_CTRL, {27'h0, ve, req, 1'b1});
		rd = 32'h0;
		for (n = 0; n < 200 && rd[1] !== 1'b1; n++) apb(1'b0, slpt_pkg::OFS_STATUS, 32'h0);
		if (rd[1] !== 1'b1) begin
			err_count++;
			close_out;
		end
		// Bench model of the walk
		mis = misc(dir, 1'b1);
		vio = dir[2:0] == 3'h0;
		lf = 1'b0;
		last = dir;
		nf = 1;
		perm = ptr[2:0] & dir[2:0];
		if (!vio && !mis && !dir[7]) begin
			nf = 2;
			lf = 1'b1;
			last = leaf;
			mis = misc(leaf, 1'b0);
			vio = leaf[2:0] == 3'h0;
			perm &= leaf[2:0];
		end
		if (!mis && !vio) vio = (req & ~perm) != 0;
		exc = vio && ve && !last[63];
		flt = mis || vio;
		chk(rd[6:0], {lf, !flt && dir[7], exc, mis, vio, 2'b10});
		chk({walk_busy, walk_done}, 2'b01);
		chk(u_mem.addrs.size(), nf);
		chk(u_mem.addrs[0], da);
		if (nf == 2) chk(u_mem.addrs[1], la);
		apb(1'b0, slpt_pkg::OFS_OUT_LO, 32'h0);
		o[31:0] = rd;
		apb(1'b0, slpt_pkg::OFS_OUT_HI, 32'h0);
		o[63:32] = rd;
		if (flt) chk(o, 64'h0);
		else if (dir[7]) chk(o, {12'h0, dir[51:21], gpa[20:0]});
		else chk(o, {12'h0, leaf[51:12], gpa[11:0]});
		apb(1'b0, slpt_pkg::OFS_ATTR, 32'h0);
		if (!flt) chk(rd[11:0], {last[63], ad & last[9], ad & last[8], last[6], 1'b0,
			last[5:3], 1'b0, perm});
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite} = 3'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		err_count = 0;
		checked = 0;
		void'($urandom(9));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, slpt_pkg::OFS_STATUS, 32'h0);
		chk(rd, slpt_pkg::RST_WORD);
		apb(1'b1, slpt_pkg::OFS_STATUS, 32'hFFFF_FFFF);
		apb(1'b0, slpt_pkg::OFS_STATUS, 32'h0);
		chk(rd, slpt_pkg::RST_WORD);
		apb(1'b0, 12'h100, 32'h0);
		chk({re, rd}, {1'b1, 32'h0});
		run(at(21) | 64'h3F7, 64'h0, 3'h1, 1'b0, 1'b1);
		run(at(21) | 64'h3F7, 64'h0, 3'h7, 1'b0, 1'b0);
		run(at(12) | 64'h107, at(12) | 64'h335, 3'h5, 1'b1, 1'b1);
		run(at(12) | 64'h78, 64'h0, 3'h1, 1'b1, 1'b0);
		run(at(12) | 64'h103, 64'h8000_0000_0000_0FF8, 3'h1, 1'b1, 1'b1);
		run(at(12) | 64'h103, 64'h0000_0000_0000_0FF8, 3'h1, 1'b0, 1'b1);
		run(at(12) | 64'h001, at(12) | 64'h037, 3'h2, 1'b1, 1'b0);
		run(at(12) | 64'h007, at(12) | 64'h036, 3'h1, 1'b0, 1'b0);
		run(at(21) | 64'h082, 64'h0, 3'h1, 1'b0, 1'b0);
		run(at(12) | 64'h006, 64'h0, 3'h1, 1'b0, 1'b0);
		run(at(21) | 64'h10B7, 64'h0, 3'h1, 1'b0, 1'b0);
		run(64'h0000_2000_0000_0000 | 64'hB7, 64'h0, 3'h1, 1'b0, 1'b0);
		run(at(21) | 64'h09F, 64'h0, 3'h1, 1'b0, 1'b0);
		run(at(12) | 64'h00F, 64'h0, 3'h1, 1'b0, 1'b0);
		run(at(12) | 64'h007, at(12) | 64'h03F, 3'h1, 1'b0, 1'b0);
		run(at(12) | 64'h007, 64'h0000_1000_0000_0037, 3'h1, 1'b0, 1'b0);
		close_out;
	end
endmodule
`default_nettype wire
